/* core/pc_stack_fsr_sequencer.v */
// Program counter, return stack, shadow context and indirect pointer sequencer.
`timescale 1ns/100ps
`include "sequencer_consts.vh"
module pc_stack_fsr_sequencer #(
    parameter PROG_WORDS = `PROG_WORDS_DEF,
    parameter SHADOW_W   = 64
) (
    input  wire                  sys_clk,
    input  wire                  reset_n,
    input  wire                  step,
    input  wire [3:0]            flow_op,
    input  wire [`PC_WIDTH-1:0]  target_addr,
    input  wire [7:0]            w_value,
    input  wire [7:0]            retlw_value,
    input  wire                  int_take,
    input  wire [SHADOW_W-1:0]   core_regs,
    input  wire                  stack_reset_enable,
    input  wire                  clear_stack_flags,
    input  wire                  fp_sel,
    input  wire                  fp_write_low,
    input  wire                  fp_write_high,
    input  wire [7:0]            fp_write_data,
    input  wire                  ind_access,
    input  wire                  ind_write,
    input  wire [13:0]           prog_rdata,
    output reg  [`PC_WIDTH-1:0]  prog_addr,
    output reg  [`PC_WIDTH-1:0]  pc,
    output reg  [3:0]            pc_page,
    output reg                   stack_overflow_flag,
    output reg                   stack_underflow_flag,
    output reg                   stack_error_reset,
    output reg  [SHADOW_W-1:0]   shadow_regs,
    output reg                   shadow_restore,
    output reg  [`FP_WIDTH-1:0]  file_pointer0,
    output reg  [`FP_WIDTH-1:0]  file_pointer1,
    output reg                   ind_data_req,
    output reg  [`FP_WIDTH-1:0]  ind_data_addr,
    output reg                   ind_data_wr,
    output reg  [7:0]            ind_prog_data,
    output reg                   ind_prog_valid,
    output reg                   stall,
    output reg  [6:0]            linear_bank,
    output reg  [6:0]            linear_offset
);
    // Implemented address width; upper bits are dropped so fetches wrap.
    localparam IMPL_W = (PROG_WORDS > 8192) ? 14 : ((PROG_WORDS > 4096) ? 13 : 12);
    localparam [`PC_WIDTH-1:0] ADDR_MASK = (15'h7FFF >> (`PC_WIDTH - IMPL_W));
    localparam ST_RUN  = 2'b01;
    localparam ST_PROG = 2'b10;

    reg  [1:0]            state;
    reg  [4:0]            depth;
    reg  [`STACK_PTR_W-1:0] top;
    reg  [`PC_WIDTH-1:0]  next_pc;
    reg                   do_push;
    reg                   do_pop;
    wire [`PC_WIDTH-1:0]  stack_rd;
    wire [`PC_WIDTH-1:0]  stack_top;
    wire [`PC_WIDTH-1:0]  inc_pc;
    reg                   push_last;
    reg  [`PC_WIDTH-1:0]  push_word;
    wire [`FP_WIDTH-1:0]  sel_fp;
    wire                  is_prog;
    wire [`FP_WIDTH-1:0]  lin_off;
    wire [12:0]           lin_bank_full;
    wire [12:0]           lin_rem;

    assign sel_fp  = fp_sel ? file_pointer1 : file_pointer0;
    assign is_prog = sel_fp[`FP_PROG_BIT];
    assign lin_off = sel_fp - `LINEAR_BASE;
    // Bank and offset inside the linear window; the quotient never exceeds 30.
    assign lin_bank_full = lin_off[12:0] / {6'h00, `GPR_PER_BANK};
    assign lin_rem       = lin_off[12:0] % {6'h00, `GPR_PER_BANK};
    // The return address is the word after the one retiring, wrapped like any fetch.
    assign inc_pc = (pc + 15'h0001) & ADDR_MASK;
    // A word pushed last cycle is not yet in the registered read, so it is forwarded.
    assign stack_top = push_last ? push_word : stack_rd;

    // Except in the cycle after a pop, the top entry is presented so a pop can use it with no extra cycle.
    // Limitation: two pops need an idle cycle between them, as the read lags one edge.
    return_stack_mem #(
        .WIDTH (`PC_WIDTH),
        .DEPTH (`STACK_DEPTH),
        .AW    (`STACK_PTR_W)
    ) u_stack (
        .sys_clk (sys_clk),
        .wr_en   (do_push && depth != `STACK_DEPTH),
        .wr_addr (depth[`STACK_PTR_W-1:0]),
        .wr_data (inc_pc),
        .rd_addr (top),
        .rd_data (stack_rd)
    );

    // Next program counter and stack action for the instruction being retired.
    always @* begin
        next_pc = inc_pc;
        do_push = 1'b0;
        do_pop  = 1'b0;
        if (int_take) begin
            next_pc = `INT_VECTOR;
            do_push = 1'b1;
        end else begin
            case (flow_op)
                `OP_CALL, `OP_CALL_VIA_W: begin
                    next_pc = target_addr & ADDR_MASK;
                    do_push = 1'b1;
                end
                `OP_RETURN, `OP_RETLW, `OP_RETURN_INT: begin
                    next_pc = stack_top & ADDR_MASK;
                    do_pop  = 1'b1;
                end
                `OP_GOTO, `OP_BRANCH_REL: begin
                    next_pc = target_addr & ADDR_MASK;
                end
                default: begin
                    next_pc = inc_pc;
                end
            endcase
        end
    end

    // Sequencer state: counter, stack pointer, flags, shadows, pointers.
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= ST_RUN;
            pc <= `RESET_VECTOR;
            prog_addr <= `RESET_VECTOR;
            pc_page <= 4'h0;
            depth <= 5'h00;
            top <= {`STACK_PTR_W{1'b0}};
            stack_overflow_flag <= 1'b0;
            stack_underflow_flag <= 1'b0;
            stack_error_reset <= 1'b0;
            shadow_regs <= {SHADOW_W{1'b0}};
            shadow_restore <= 1'b0;
            file_pointer0 <= 16'h0000;
            file_pointer1 <= 16'h0000;
            ind_data_req <= 1'b0;
            ind_data_addr <= 16'h0000;
            ind_data_wr <= 1'b0;
            ind_prog_data <= 8'h00;
            ind_prog_valid <= 1'b0;
            stall <= 1'b0;
            linear_bank <= 7'h00;
            linear_offset <= 7'h00;
            push_last <= 1'b0;
            push_word <= `RESET_VECTOR;
        end else begin
            shadow_restore <= 1'b0;
            stack_error_reset <= 1'b0;
            ind_data_req <= 1'b0;
            ind_data_wr <= 1'b0;
            ind_prog_valid <= 1'b0;
            push_last <= 1'b0;
            // A flag raised in the same cycle as a clear stays set.
            if (clear_stack_flags) begin
                stack_overflow_flag <= 1'b0;
                stack_underflow_flag <= 1'b0;
            end
            // Pointer byte writes from the decoder.
            if (fp_write_low && !fp_sel) file_pointer0[7:0] <= fp_write_data;
            if (fp_write_high && !fp_sel) file_pointer0[15:8] <= fp_write_data;
            if (fp_write_low && fp_sel) file_pointer1[7:0] <= fp_write_data;
            if (fp_write_high && fp_sel) file_pointer1[15:8] <= fp_write_data;
            case (state)
                ST_RUN: begin
                    if (step && ind_access && is_prog && !int_take) begin
                        // Program memory read costs one extra cycle.
                        state <= ST_PROG;
                        stall <= 1'b1;
                        prog_addr <= sel_fp[`PC_WIDTH-1:0] & ADDR_MASK;
                    end else if (step) begin
                        pc <= next_pc;
                        prog_addr <= next_pc;
                        pc_page <= next_pc[`PC_WIDTH-1:`PAGE_BIT_LO];
                        if (do_push) begin
                            if (depth == `STACK_DEPTH) begin
                                stack_overflow_flag <= 1'b1;
                                stack_error_reset <= stack_reset_enable;
                            end else begin
                                top <= depth[`STACK_PTR_W-1:0];
                                push_last <= 1'b1;
                                push_word <= inc_pc;
                                depth <= depth + 5'h01;
                            end
                        end
                        if (do_pop) begin
                            if (depth == 5'h00) begin
                                stack_underflow_flag <= 1'b1;
                                stack_error_reset <= stack_reset_enable;
                            end else begin
                                top <= top - 4'h1;
                                depth <= depth - 5'h01;
                            end
                        end
                        if (int_take) shadow_regs <= core_regs;
                        if (!int_take && flow_op == `OP_RETURN_INT) begin
                            shadow_restore <= 1'b1;
                        end
                        // Data side indirect access; program side writes are dropped.
                        if (ind_access && !is_prog) begin
                            ind_data_req <= 1'b1;
                            ind_data_addr <= sel_fp;
                            ind_data_wr <= ind_write;
                            if (sel_fp >= `LINEAR_BASE && sel_fp <= `LINEAR_TOP) begin
                                linear_bank <= lin_bank_full[6:0];
                                linear_offset <= `GPR_BANK_BASE + lin_rem[6:0];
                            end
                        end
                    end
                end
                ST_PROG: begin
                    // Only the low byte of the word goes back; a write is ignored.
                    ind_prog_data <= prog_rdata[7:0];
                    ind_prog_valid <= 1'b1;
                    stall <= 1'b0;
                    // The stalled instruction only moves on; an interrupt waits for a step.
                    pc <= inc_pc;
                    prog_addr <= inc_pc;
                    pc_page <= inc_pc[`PC_WIDTH-1:`PAGE_BIT_LO];
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end
endmodule

/* core/sequencer_consts.vh */
// Constants shared by the program sequencer and its return stack.
//
// Contract
// - Program counter is 15 bits, addressing 32K words of 14 bits.
// - Implemented program memory is a parameter of 4096, 8192 or 16384 words.
// - Addresses beyond implemented memory wrap by dropping unused upper bits.
// - Fetch starts at 0000h after reset; interrupts branch to 0004h.
// - Return stack is a separate memory, 15 bits wide, 16 deep.
// - Push on full sets overflow flag; pop on empty sets underflow flag.
// - With stack reset option on, a stack error also requests a device reset.
// - Interrupt entry copies core registers into shadow registers automatically.
// - Return from interrupt restores core registers from the shadow copies.
// - Two 16-bit pointers reach all file registers and program memory.
// - Indirect access to program memory takes exactly one extra cycle; on a step that also takes an interrupt it is dropped, with no stall.
// - General purpose RAM is reachable as one linear address range.
// - The feeding decoder implements 49 instructions.
// - Pointer high byte bit 7 set selects program memory, clear selects data.
// - Indirect program read delivers only the low 8 bits of the word.
// - Indirect writes to program memory have no effect.
`ifndef SEQUENCER_CONSTS_VH
`define SEQUENCER_CONSTS_VH
`define PC_WIDTH        15
`define PROG_WORDS_DEF  16384
`define STACK_DEPTH     16
`define STACK_PTR_W     4
`define RESET_VECTOR    15'h0000
`define INT_VECTOR      15'h0004
`define PAGE_BIT_LO     11
`define FP_WIDTH        16
`define FP_PROG_BIT     15
`define LINEAR_BASE     16'h2000
`define LINEAR_TOP      16'h29AF
`define GPR_PER_BANK    7'h50
`define GPR_BANK_BASE   7'h20
`define INSTR_COUNT     49
`define OP_NONE         4'h0
`define OP_CALL         4'h1
`define OP_CALL_VIA_W   4'h2
`define OP_RETURN       4'h3
`define OP_RETLW        4'h4
`define OP_RETURN_INT   4'h5
`define OP_GOTO         4'h6
`define OP_BRANCH_REL   4'h7
`endif

/* core/return_stack_mem.v */
// Return address memory of the hardware stack, with registered read data.
`timescale 1ns/100ps
`include "sequencer_consts.vh"
module return_stack_mem #(
    parameter WIDTH = `PC_WIDTH,
    parameter DEPTH = `STACK_DEPTH,
    parameter AW    = `STACK_PTR_W
) (
    input  wire             sys_clk,
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // Write and registered read; the read sees the old word on a same-address write.
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* testbench/seq_checker_sva.sv */
// Concurrent checks on the program sequencer ports.
`timescale 1ns/100ps
`include "sequencer_consts.vh"
module seq_checker #(
    parameter PROG_WORDS = 16384,
    parameter SHADOW_W   = 64
) (
    input wire logic                sys_clk,
    input wire logic                reset_n,
    input wire logic                step,
    input wire logic [3:0]          flow_op,
    input wire logic [14:0]         target_addr,
    input wire logic                int_take,
    input wire logic [SHADOW_W-1:0] core_regs,
    input wire logic                stack_reset_enable,
    input wire logic                clear_stack_flags,
    input wire logic                fp_sel,
    input wire logic                ind_access,
    input wire logic [13:0]         prog_rdata,
    input wire logic [14:0]         pc,
    input wire logic                stack_overflow_flag,
    input wire logic                stack_underflow_flag,
    input wire logic                stack_error_reset,
    input wire logic [SHADOW_W-1:0] shadow_regs,
    input wire logic [15:0]         file_pointer0,
    input wire logic [15:0]         file_pointer1,
    input wire logic                ind_data_wr,
    input wire logic [15:0]         ind_data_addr,
    input wire logic [7:0]          ind_prog_data,
    input wire logic                ind_prog_valid,
    input wire logic                stall
);
    // A step only counts outside a stall, since a stalled step is dropped.
    wire go = step && !stall;
    wire prog_sel = fp_sel ? file_pointer1[15] : file_pointer0[15];
    wire [7:0] prog_low = prog_rdata[7:0];
    wire jump = flow_op == `OP_CALL || flow_op == `OP_GOTO;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    reset_vec_a: assert property ($rose(reset_n) |-> pc == `RESET_VECTOR)
        else $error("pc not at reset vector");
    int_vec_a: assert property (go && int_take |=> pc == `INT_VECTOR)
        else $error("interrupt did not branch to vector");
    jump_wrap_a: assert property (go && !int_take && !ind_access && jump
        |=> pc == (target_addr & (PROG_WORDS - 1))) else $error("jump target not wrapped");
    prog_extra_a: assert property (go && !int_take && ind_access && prog_sel
        |=> stall ##1 (!stall && ind_prog_valid)) else $error("program access not one cycle");
    data_fast_a: assert property (go && ind_access && !prog_sel |=> !stall)
        else $error("data access stalled");
    low_byte_a: assert property (ind_prog_valid |-> ind_prog_data == $past(prog_low))
        else $error("program read byte wrong");
    no_prog_write_a: assert property (ind_data_wr |-> !ind_data_addr[15])
        else $error("write reached program space");
    err_reset_a: assert property (stack_error_reset |-> $past(stack_reset_enable)
        && (stack_overflow_flag || stack_underflow_flag)) else $error("bad stack reset");
    flag_sticky_a: assert property (stack_overflow_flag && !clear_stack_flags
        |=> stack_overflow_flag) else $error("overflow flag dropped");
    shadow_copy_a: assert property (go && int_take |=> shadow_regs == $past(core_regs))
        else $error("shadow copy wrong");
    int_c: cover property (go && int_take);
    ovf_c: cover property ($rose(stack_overflow_flag));
    prog_c: cover property (ind_prog_valid);
endmodule
bind pc_stack_fsr_sequencer seq_checker #(.PROG_WORDS(PROG_WORDS), .SHADOW_W(SHADOW_W))
    u_seq_checker (.sys_clk, .reset_n, .step, .flow_op, .target_addr, .int_take, .core_regs,
    .stack_reset_enable, .clear_stack_flags, .fp_sel, .ind_access, .prog_rdata, .pc,
    .stack_overflow_flag, .stack_underflow_flag, .stack_error_reset, .shadow_regs,
    .file_pointer0, .file_pointer1, .ind_data_wr, .ind_data_addr, .ind_prog_data,
    .ind_prog_valid, .stall);

/* testbench/prog_mem_model.sv */
// Behavioural program memory answering the sequencer's fetch address.
`timescale 1ns/100ps
module prog_mem_model (
    input  wire logic [14:0] prog_addr,
    output wire logic [13:0] prog_rdata
);
    // Words scramble the low 14 address bits, so a wrong address in those bits never reads back right; bit 14 is ignored.
    assign prog_rdata = prog_addr[13:0] ^ 14'h1A5C;
endmodule

/* testbench/pc_stack_fsr_sequencer_tb_top.sv */
// Self-checking bench for the program sequencer.
`timescale 1ns/100ps
`include "sequencer_consts.vh"
module pc_stack_fsr_sequencer_tb_top;
    logic        sys_clk = 0, reset_n = 0, step = 0, int_take = 0, stack_reset_enable = 0;
    logic        clear_stack_flags = 0, fp_sel = 0, fp_write_low = 0, fp_write_high = 0;
    logic        ind_access = 0, ind_write = 0, seen_err = 0, seen_dwr = 0;
    logic [3:0]  flow_op = 0;
    logic [14:0] target_addr = 0;
    logic [7:0]  w_value = 0, retlw_value = 0, fp_write_data = 0;
    logic [63:0] core_regs = 64'h0123456789ABCDEF;
    wire  [13:0] prog_rdata;
    wire  [14:0] prog_addr, pc;
    wire  [3:0]  pc_page;
    wire  [63:0] shadow_regs;
    wire  [15:0] file_pointer0, file_pointer1, ind_data_addr;
    wire  [7:0]  ind_prog_data;
    wire  [6:0]  linear_bank, linear_offset;
    wire         stack_overflow_flag, stack_underflow_flag, stack_error_reset, shadow_restore;
    wire         ind_data_req, ind_data_wr, ind_prog_valid, stall;
    int          n_mismatch = 0, comparisons = 0, i;
    // Rows: operation, target, pc expected; 4096 words so high targets must wrap.
    logic [33:0] rows [9] = '{{4'h6, 15'h7FFF, 15'h0FFF}, {4'h0, 15'h0000, 15'h0000},
        {4'h6, 15'h0123, 15'h0123}, {4'h1, 15'h1100, 15'h0100}, {4'h0, 15'h0000, 15'h0101},
        {4'h4, 15'h0000, 15'h0124}, {4'h1, 15'h0200, 15'h0200}, {4'h0, 15'h0000, 15'h0201},
        {4'h3, 15'h0000, 15'h0125}};
    pc_stack_fsr_sequencer #(.PROG_WORDS(4096)) u_pc_stack_fsr_sequencer (
        .sys_clk(sys_clk), .reset_n(reset_n), .step(step), .flow_op(flow_op),
        .target_addr(target_addr), .w_value(w_value), .retlw_value(retlw_value),
        .int_take(int_take), .core_regs(core_regs), .stack_reset_enable(stack_reset_enable),
        .clear_stack_flags(clear_stack_flags), .fp_sel(fp_sel), .fp_write_low(fp_write_low),
        .fp_write_high(fp_write_high), .fp_write_data(fp_write_data), .ind_access(ind_access),
        .ind_write(ind_write), .prog_rdata(prog_rdata), .prog_addr(prog_addr), .pc(pc),
        .pc_page(pc_page), .stack_overflow_flag(stack_overflow_flag),
        .stack_underflow_flag(stack_underflow_flag), .stack_error_reset(stack_error_reset),
        .shadow_regs(shadow_regs), .shadow_restore(shadow_restore),
        .file_pointer0(file_pointer0), .file_pointer1(file_pointer1),
        .ind_data_req(ind_data_req), .ind_data_addr(ind_data_addr), .ind_data_wr(ind_data_wr),
        .ind_prog_data(ind_prog_data), .ind_prog_valid(ind_prog_valid), .stall(stall),
        .linear_bank(linear_bank), .linear_offset(linear_offset));
    prog_mem_model u_prog_mem_model (.prog_addr(prog_addr), .prog_rdata(prog_rdata));
    initial forever #5 sys_clk = ~sys_clk;
    // Short pulses are latched so a check a cycle late still sees them; reset clears them.
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            seen_err <= 0;
            seen_dwr <= 0;
        end else begin
            if (stack_error_reset) seen_err <= 1;
            if (ind_data_wr) seen_dwr <= 1;
        end
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    // One step, then an idle cycle, which keeps pops legally spaced.
    task run(input logic [3:0] op, input logic [14:0] tgt, input logic it, ia, iw);
        @(posedge sys_clk);
        step <= 1; flow_op <= op; target_addr <= tgt; int_take <= it;
        ind_access <= ia; ind_write <= iw;
        @(posedge sys_clk);
        step <= 0; flow_op <= 0; int_take <= 0; ind_access <= 0; ind_write <= 0;
        #1;
    endtask
    task ptr(input logic sel, input logic [15:0] v);
        @(posedge sys_clk);
        fp_sel <= sel; fp_write_high <= 1; fp_write_data <= v[15:8];
        @(posedge sys_clk);
        fp_write_high <= 0; fp_write_low <= 1; fp_write_data <= v[7:0];
        @(posedge sys_clk);
        fp_write_low <= 0;
    endtask
    task rst;
        @(posedge sys_clk);
        reset_n <= 0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1;
        #1;
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #50000;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        rst;
        chk(pc, `RESET_VECTOR);
        for (i = 0; i < 9; i++) begin
            run(rows[i][33:30], rows[i][29:15], 0, 0, 0);
            chk(pc, rows[i][14:0]);
        end
        run(6, 15'h0A00, 0, 0, 0);
        chk({pc_page, pc}, {4'h1, 15'h0A00});
        run(0, 0, 1, 0, 0);
        chk(pc, `INT_VECTOR);
        chk(shadow_regs, 64'h0123456789ABCDEF);
        @(posedge sys_clk) core_regs <= 64'h0;
        run(5, 0, 0, 0, 0);
        chk(shadow_restore, 1);
        chk(shadow_regs, 64'h0123456789ABCDEF);
        chk(pc, 15'h0A01);
        ptr(0, 16'h8345);
        run(0, 0, 0, 1, 0);
        chk({stall, prog_addr}, {1'b1, 15'h0345});
        chk(file_pointer0, 16'h8345);
        @(posedge sys_clk) #1;
        chk({stall, ind_prog_valid, ind_prog_data}, {2'b01, 8'h45 ^ 8'h5C});
        run(0, 0, 0, 1, 1);
        repeat (2) @(posedge sys_clk) #1;
        chk(seen_dwr, 0);
        ptr(1, 16'h2055);
        run(0, 0, 0, 1, 1);
        chk({stall, ind_data_req, ind_data_wr, ind_data_addr}, {3'b011, 16'h2055});
        chk(file_pointer1, 16'h2055);
        chk({linear_bank, linear_offset}, {7'h01, 7'h25});
        @(posedge sys_clk) stack_reset_enable <= 1;
        rst;
        chk(pc, `RESET_VECTOR);
        for (i = 0; i < 16; i++) run(1, 15'h0010, 0, 0, 0);
        chk(stack_overflow_flag, 0);
        run(1, 15'h0010, 0, 0, 0);
        chk(stack_overflow_flag, 1);
        @(posedge sys_clk) clear_stack_flags <= 1;
        @(posedge sys_clk) clear_stack_flags <= 0;
        #1 chk({seen_err, stack_overflow_flag}, 2'b10);
        @(posedge sys_clk) stack_reset_enable <= 0;
        rst;
        chk({seen_err, pc}, {1'b0, `RESET_VECTOR});
        run(3, 0, 0, 0, 0);
        @(posedge sys_clk) #1;
        chk({stack_underflow_flag, seen_err}, 2'b10);
        tally_and_finish;
    end
endmodule
